/* common/fault_cache_pkg.sv */
// Shared constants and types for the fault record and cache maintenance block.
package fault_cache_pkg;

  localparam logic [3:0] CRN_FAULT_STATUS = 4'h5;
  localparam logic [3:0] CRN_FAULT_ADDRESS = 4'h6;
  localparam logic [3:0] CRN_CACHE_OPS = 4'h7;

  localparam logic [2:0] SEL_DATA_STATUS = 3'h0;
  localparam logic [2:0] SEL_INSTR_STATUS = 3'h1;

  localparam int FSR_ZERO_BIT = 8;
  localparam int FSR_STATUS_W = 4;

  localparam int TEST_RESULT_BIT = 30;

  localparam int ADDR_W = 32;
  localparam int LINE_OFFSET_W = 5;
  localparam logic [31:0] WFI_LINK_OFFSET = 32'h0000_0008;

  // Fault kinds, index 0 is the highest priority, index 9 the lowest.
  // 0 alignment, 1/2 walk abort first/second level, 3/4 translation section/page,
  // 5/6 domain section/page, 7/8 permission section/page, 9 external abort.
  localparam int FAULT_KINDS = 10;
  localparam logic [39:0] FAULT_CODE_TABLE = 40'h8f_db97_5ec1;
  localparam logic [9:0] FAULT_DOMAIN_VALID = 10'h1f4;

  localparam logic [31:0] FAULT_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] FAULT_ADDRESS_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_UNPREDICTABLE = 32'h0000_0000;

  // Cache keys: {minor register, secondary opcode}.
  localparam logic [6:0] KEY_INV_BOTH = {4'h7, 3'h0};
  localparam logic [6:0] KEY_INV_IC = {4'h5, 3'h0};
  localparam logic [6:0] KEY_INV_IC_ADDR = {4'h5, 3'h1};
  localparam logic [6:0] KEY_INV_IC_SETWAY = {4'h5, 3'h2};
  localparam logic [6:0] KEY_PREFETCH_IC = {4'hd, 3'h1};
  localparam logic [6:0] KEY_INV_DC = {4'h6, 3'h0};
  localparam logic [6:0] KEY_INV_DC_ADDR = {4'h6, 3'h1};
  localparam logic [6:0] KEY_INV_DC_SETWAY = {4'h6, 3'h2};
  localparam logic [6:0] KEY_CLEAN_ADDR = {4'ha, 3'h1};
  localparam logic [6:0] KEY_CLEAN_SETWAY = {4'ha, 3'h2};
  localparam logic [6:0] KEY_TEST_CLEAN = {4'ha, 3'h3};
  localparam logic [6:0] KEY_DRAIN = {4'ha, 3'h4};
  localparam logic [6:0] KEY_CI_ADDR = {4'he, 3'h1};
  localparam logic [6:0] KEY_CI_SETWAY = {4'he, 3'h2};
  localparam logic [6:0] KEY_TEST_CI = {4'he, 3'h3};
  localparam logic [6:0] KEY_WFI = {4'h0, 3'h4};

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INV_ALL = 3'b001,
    OP_INV_LINE = 3'b010,
    OP_CLEAN = 3'b011,
    OP_FILL = 3'b100,
    OP_DIRTY = 3'b101
  } line_op_e;

  typedef enum logic [4:0] {
    CMD_NONE = 5'b00000,
    CMD_INV_BOTH = 5'b00001,
    CMD_INV_IC = 5'b00010,
    CMD_INV_IC_ADDR = 5'b00011,
    CMD_INV_IC_SETWAY = 5'b00100,
    CMD_PREFETCH_IC = 5'b00101,
    CMD_INV_DC = 5'b00110,
    CMD_INV_DC_ADDR = 5'b00111,
    CMD_INV_DC_SETWAY = 5'b01000,
    CMD_CLEAN_ADDR = 5'b01001,
    CMD_CLEAN_SETWAY = 5'b01010,
    CMD_CI_ADDR = 5'b01011,
    CMD_CI_SETWAY = 5'b01100,
    CMD_TEST_CLEAN = 5'b01101,
    CMD_TEST_CI = 5'b01110,
    CMD_DRAIN = 5'b01111,
    CMD_WFI = 5'b10000
  } cache_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_TEST = 3'b010,
    ST_WB = 3'b011,
    ST_RESULT = 3'b100,
    ST_LF = 3'b101,
    ST_DRAIN = 3'b110,
    ST_SLEEP = 3'b111
  } ctrl_state_e;

endpackage

/* common/line_ops_if.sv */
// Carrier between the controller and one cache line state array.
`timescale 1ns/1ps
interface line_ops_if #(
  parameter int IDX_W = 7
);
  import fault_cache_pkg::*;
  localparam int TAG_W = ADDR_W - LINE_OFFSET_W - IDX_W;
  line_op_e op;
  logic [IDX_W-1:0] idx;
  logic [TAG_W-1:0] tag;
  logic by_addr;
  logic valid;
  logic dirty;
  logic hit;
  logic any_dirty;
  logic [TAG_W-1:0] tag_out;
  modport ctrl (
    output op, idx, tag, by_addr,
    input valid, dirty, hit, any_dirty, tag_out
  );
  modport store (
    input op, idx, tag, by_addr,
    output valid, dirty, hit, any_dirty, tag_out
  );
endinterface

/* rtl/fault_record_cache_maintenance.sv */
// Fault status and address recording plus cache maintenance command decode.
//
// How it works
// [R1] Status bit 8 reads zero and drops writes; upper bits kept.
// [R2] Data faults record the domain number in status bits 7 to 4.
// [R3] Alignment is 0001, highest; external abort 1000, lowest; both lack domain.
// [R4] Walk aborts: 1100 first level, no domain; 1110 second level, with domain.
// [R5] Translation 0101/0111, domain 1001/1011, permission 1101/1111; 0101 lacks domain.
// [R6] A data abort stores the faulting address in the fault address register.
// [R7] Prefetch aborts never touch the fault address register.
// [R8] A coprocessor write loads the fault address register directly.
// [R9] Minor register number and secondary opcode select the cache command.
// [R10] Cache operation reads return zero except for the two test commands.
// [R11] Whole-cache invalidate clears every line, dropping dirty data.
// [R12] Single-line invalidate, by index or address, drops one line and its dirty data.
// [R13] Single-line clean writes back a valid dirty line, clears dirty, keeps valid.
// [R14] Clean-and-invalidate writes back a valid dirty line, then invalidates it.
// [R15] Test-and-clean scans lines, cleans one dirty line, reports in bit 30.
// [R16] Test-clean-invalidate also invalidates the data cache once nothing is dirty.
// [R17] Prefetch fills the instruction cache on a cacheable miss.
// [R18] Drain finishes only with the write buffer empty; the core stalls meanwhile.
// [R19] Wait-for-interrupt drains, sleeps until woken, then links address plus eight.
// [R20] Minor 7 op 0 invalidates both caches; minor 5 op 0 the instruction cache.
// [R21] Minor 5 op 1/2 invalidate one instruction line; minor 13 op 1 prefetches.
// [R22] Minor 6 op 0 invalidates the data cache; op 1 one data line by address.
// [R23] Test result bit 30 is 0 while dirty lines remain, else 1.
// [R24] Fault registers hold without aborts or writes; read data holds until the next read.
`timescale 1ns/1ps
module fault_record_cache_maintenance
  import fault_cache_pkg::*;
#(
  parameter int DC_IDX_W = 7,
  parameter int IC_IDX_W = 7,
  parameter int TEST_LINES = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_major,
  input wire logic [3:0] cp_minor,
  input wire logic [2:0] cp_secondary,
  input wire logic [31:0] cp_wdata,
  input wire logic [31:0] cp_pc,
  output logic cp_busy,
  output logic cp_done,
  output logic [31:0] cp_rdata,
  input wire logic abort_valid,
  input wire logic abort_data,
  input wire logic [9:0] abort_kinds,
  input wire logic [3:0] abort_domain,
  input wire logic [31:0] abort_addr,
  input wire logic dc_fill_valid,
  input wire logic [31:0] dc_fill_addr,
  input wire logic dc_store_valid,
  input wire logic [31:0] dc_store_addr,
  input wire logic ic_fill_valid,
  input wire logic [31:0] ic_fill_addr,
  output logic wb_req,
  output logic [31:0] wb_addr,
  input wire logic wb_ack,
  output logic lf_req,
  output logic [31:0] lf_addr,
  input wire logic lf_ack,
  input wire logic pf_cacheable,
  input wire logic wbuf_empty,
  input wire logic irq_pin,
  input wire logic fiq_pin,
  input wire logic dbg_req_pin,
  output logic low_power,
  output logic [31:0] wfi_link
);
  localparam int DC_TAG_W = ADDR_W - LINE_OFFSET_W - DC_IDX_W;
  localparam int IC_TAG_W = ADDR_W - LINE_OFFSET_W - IC_IDX_W;

  if (DC_IDX_W < 1 || DC_IDX_W > 20 || IC_IDX_W < 1 || IC_IDX_W > 20 ||
      TEST_LINES < 1 || TEST_LINES > 65535) begin : g_bad_params
    $error("Index widths must be 1 to 20 and TEST_LINES 1 to 65535.");
  end

  line_ops_if #(.IDX_W(DC_IDX_W)) dc_if ();
  line_ops_if #(.IDX_W(IC_IDX_W)) ic_if ();

  line_state_array #(.IDX_W(DC_IDX_W)) u_dc_lines (
    .clk(clk),
    .rst_b(rst_b),
    .ops(dc_if.store)
  );
  line_state_array #(.IDX_W(IC_IDX_W)) u_ic_lines (
    .clk(clk),
    .rst_b(rst_b),
    .ops(ic_if.store)
  );

  ctrl_state_e state_reg, state_next;
  logic write_reg;
  logic [3:0] major_reg;
  logic [6:0] key_reg;
  logic [31:0] wdata_reg;
  logic [31:0] pc_reg;
  logic [31:0] data_status_reg;
  logic [31:0] instr_status_reg;
  logic [31:0] fault_address_reg;
  logic [DC_IDX_W-1:0] scan_ptr_reg;
  logic [15:0] test_cnt_reg;
  logic [2:0] wake_meta_reg;
  logic [2:0] wake_sync_reg;
  logic busy_reg;
  logic done_reg;
  logic [31:0] rdata_reg;
  logic wb_req_reg;
  logic [31:0] wb_addr_reg;
  logic lf_req_reg;
  logic [31:0] lf_addr_reg;
  logic low_power_reg;
  logic [31:0] wfi_link_reg;

  line_op_e dc_op;
  line_op_e ic_op;
  logic finish;
  logic wb_start;
  logic lf_start;
  logic scan_adv;
  logic [31:0] rdata_next;

  // Picks the highest-priority fault kind that is flagged.
  function automatic logic [3:0] pick_kind(input logic [9:0] kinds);
    logic [3:0] sel;
    sel = 4'h9;
    for (int k = FAULT_KINDS - 1; k >= 0; k--) begin
      if (kinds[k]) begin
        sel = 4'(k);
      end
    end
    return sel;
  endfunction

  function automatic cache_cmd_e decode_cmd(input logic wr, input logic [3:0] major,
                                            input logic [6:0] key);
    cache_cmd_e cmd;
    cmd = CMD_NONE;
    if (major == CRN_CACHE_OPS && wr) begin
      case (key)
        KEY_INV_BOTH: cmd = CMD_INV_BOTH;
        KEY_INV_IC: cmd = CMD_INV_IC;
        KEY_INV_IC_ADDR: cmd = CMD_INV_IC_ADDR;
        KEY_INV_IC_SETWAY: cmd = CMD_INV_IC_SETWAY;
        KEY_PREFETCH_IC: cmd = CMD_PREFETCH_IC;
        KEY_INV_DC: cmd = CMD_INV_DC;
        KEY_INV_DC_ADDR: cmd = CMD_INV_DC_ADDR;
        KEY_INV_DC_SETWAY: cmd = CMD_INV_DC_SETWAY;
        KEY_CLEAN_ADDR: cmd = CMD_CLEAN_ADDR;
        KEY_CLEAN_SETWAY: cmd = CMD_CLEAN_SETWAY;
        KEY_CI_ADDR: cmd = CMD_CI_ADDR;
        KEY_CI_SETWAY: cmd = CMD_CI_SETWAY;
        KEY_DRAIN: cmd = CMD_DRAIN;
        KEY_WFI: cmd = CMD_WFI;
        default: cmd = CMD_NONE;
      endcase
    end else if (major == CRN_CACHE_OPS) begin
      case (key)
        KEY_TEST_CLEAN: cmd = CMD_TEST_CLEAN;
        KEY_TEST_CI: cmd = CMD_TEST_CI;
        default: cmd = CMD_NONE;
      endcase
    end
    return cmd;
  endfunction

  wire cache_cmd_e cmd = decode_cmd(write_reg, major_reg, key_reg); // [R9] [R20] [R21] [R22]
  wire logic take = cp_valid && (state_reg == ST_IDLE);
  wire logic in_exec = state_reg == ST_EXEC;
  wire logic wake = |wake_sync_reg;
  wire logic cmd_test = (cmd == CMD_TEST_CLEAN) || (cmd == CMD_TEST_CI);
  wire logic cmd_ci = (cmd == CMD_CI_ADDR) || (cmd == CMD_CI_SETWAY);
  wire logic dc_by_addr_cmd = (cmd == CMD_INV_DC_ADDR) || (cmd == CMD_CLEAN_ADDR) ||
                              (cmd == CMD_CI_ADDR);
  wire logic dc_sel_ok = dc_by_addr_cmd ? dc_if.hit : dc_if.valid;
  wire logic [DC_IDX_W-1:0] dc_cmd_idx = wdata_reg[LINE_OFFSET_W +: DC_IDX_W];
  wire logic [IC_IDX_W-1:0] ic_cmd_idx = wdata_reg[LINE_OFFSET_W +: IC_IDX_W];
  wire logic [DC_IDX_W-1:0] dc_fill_idx = dc_fill_valid ?
      dc_fill_addr[LINE_OFFSET_W +: DC_IDX_W] : dc_store_addr[LINE_OFFSET_W +: DC_IDX_W];
  wire logic [DC_TAG_W-1:0] dc_fill_tag = dc_fill_valid ?
      dc_fill_addr[ADDR_W-1 -: DC_TAG_W] : dc_store_addr[ADDR_W-1 -: DC_TAG_W];

  assign dc_if.op = dc_op;
  assign dc_if.idx = (state_reg == ST_IDLE) ? dc_fill_idx :
                     (cmd_test ? scan_ptr_reg : dc_cmd_idx);
  assign dc_if.tag = (state_reg == ST_IDLE) ? dc_fill_tag : wdata_reg[ADDR_W-1 -: DC_TAG_W];
  assign dc_if.by_addr = in_exec && dc_by_addr_cmd;
  assign ic_if.op = ic_op;
  assign ic_if.idx = (state_reg == ST_IDLE) ? ic_fill_addr[LINE_OFFSET_W +: IC_IDX_W] :
                     ic_cmd_idx;
  assign ic_if.tag = (state_reg == ST_IDLE) ? ic_fill_addr[ADDR_W-1 -: IC_TAG_W] :
                     wdata_reg[ADDR_W-1 -: IC_TAG_W];
  assign ic_if.by_addr = in_exec && (cmd == CMD_INV_IC_ADDR);

  wire logic [3:0] fault_kind = pick_kind(abort_kinds);
  wire logic [3:0] fault_code = FAULT_CODE_TABLE[4*fault_kind +: FSR_STATUS_W]; // [R3] [R4] [R5]
  wire logic [3:0] fault_domain = FAULT_DOMAIN_VALID[fault_kind] ? abort_domain : 4'h0; // [R2]
  wire logic [31:0] fault_word = {23'h00_0000, 1'b0, fault_domain, fault_code};
  wire logic abort_now = abort_valid && (|abort_kinds);
  wire logic reg_wr = in_exec && write_reg;
  wire logic wr_data_status = reg_wr && major_reg == CRN_FAULT_STATUS &&
                              key_reg[2:0] == SEL_DATA_STATUS;
  wire logic wr_instr_status = reg_wr && major_reg == CRN_FAULT_STATUS &&
                               key_reg[2:0] == SEL_INSTR_STATUS;
  wire logic wr_fault_address = reg_wr && major_reg == CRN_FAULT_ADDRESS;
  wire logic [31:0] status_wdata = {wdata_reg[31:FSR_ZERO_BIT+1], 1'b0, // [R1]
                                    wdata_reg[FSR_ZERO_BIT-1:0]};
  wire logic [31:0] test_result = 32'(!dc_if.any_dirty) << TEST_RESULT_BIT; // [R15] [R23]

  always_comb begin
    rdata_next = RDATA_UNPREDICTABLE; // [R10]
    if (major_reg == CRN_FAULT_STATUS) begin
      rdata_next = (key_reg[2:0] == SEL_INSTR_STATUS) ? instr_status_reg : data_status_reg;
    end else if (major_reg == CRN_FAULT_ADDRESS) begin
      rdata_next = fault_address_reg;
    end else if (cmd_test) begin
      rdata_next = test_result; // [R10]
    end
  end

  always_comb begin
    state_next = state_reg;
    dc_op = OP_NONE;
    ic_op = OP_NONE;
    finish = 1'b0;
    wb_start = 1'b0;
    lf_start = 1'b0;
    scan_adv = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (dc_fill_valid) begin
          dc_op = OP_FILL;
        end else if (dc_store_valid) begin
          dc_op = OP_DIRTY;
        end
        if (ic_fill_valid) begin
          ic_op = OP_FILL;
        end
        if (take) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        unique case (cmd)
          CMD_NONE: finish = 1'b1;
          CMD_INV_BOTH: begin
            dc_op = OP_INV_ALL; // [R11] [R20]
            ic_op = OP_INV_ALL;
            finish = 1'b1;
          end
          CMD_INV_IC: begin
            ic_op = OP_INV_ALL; // [R11] [R20]
            finish = 1'b1;
          end
          CMD_INV_IC_ADDR, CMD_INV_IC_SETWAY: begin
            ic_op = OP_INV_LINE; // [R12] [R21]
            finish = 1'b1;
          end
          CMD_INV_DC: begin
            dc_op = OP_INV_ALL; // [R11] [R22]
            finish = 1'b1;
          end
          CMD_INV_DC_ADDR, CMD_INV_DC_SETWAY: begin
            dc_op = OP_INV_LINE; // [R12] [R22]
            finish = 1'b1;
          end
          CMD_CLEAN_ADDR, CMD_CLEAN_SETWAY, CMD_CI_ADDR, CMD_CI_SETWAY: begin
            if (dc_sel_ok && dc_if.dirty) begin
              wb_start = 1'b1; // [R13] [R14]
              state_next = ST_WB;
            end else begin
              dc_op = cmd_ci ? OP_INV_LINE : OP_NONE; // [R14]
              finish = 1'b1;
            end
          end
          CMD_TEST_CLEAN, CMD_TEST_CI: state_next = ST_TEST;
          CMD_PREFETCH_IC: begin
            if (ic_if.hit || !pf_cacheable) begin
              finish = 1'b1;
            end else begin
              lf_start = 1'b1; // [R17]
              state_next = ST_LF;
            end
          end
          CMD_DRAIN, CMD_WFI: state_next = ST_DRAIN;
        endcase
      end
      ST_TEST: begin
        if (dc_if.valid && dc_if.dirty) begin
          wb_start = 1'b1; // [R15]
          state_next = ST_WB;
        end else begin
          scan_adv = 1'b1;
          if (test_cnt_reg == 16'(TEST_LINES - 1)) begin
            state_next = ST_RESULT;
          end
        end
      end
      ST_WB: begin
        if (wb_ack) begin
          dc_op = cmd_ci ? OP_INV_LINE : OP_CLEAN; // [R13] [R14] [R15]
          if (cmd_test) begin
            scan_adv = 1'b1;
            state_next = ST_RESULT;
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_RESULT: begin
        if (cmd == CMD_TEST_CI && !dc_if.any_dirty) begin
          dc_op = OP_INV_ALL; // [R16]
        end
        finish = 1'b1;
      end
      ST_LF: begin
        if (lf_ack) begin
          ic_op = OP_FILL; // [R17]
          finish = 1'b1;
        end
      end
      ST_DRAIN: begin
        if (wbuf_empty) begin
          if (cmd == CMD_WFI) begin
            state_next = ST_SLEEP; // [R19]
          end else begin
            finish = 1'b1; // [R18]
          end
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          finish = 1'b1; // [R19]
        end
      end
    endcase
    if (finish) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      low_power_reg <= 1'b0;
      wake_meta_reg <= 3'h0;
      wake_sync_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      busy_reg <= state_next != ST_IDLE; // [R18]
      done_reg <= finish;
      low_power_reg <= state_next == ST_SLEEP; // [R19]
      wake_meta_reg <= {dbg_req_pin, fiq_pin, irq_pin};
      wake_sync_reg <= wake_meta_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_reg <= 1'b0;
      major_reg <= 4'h0;
      key_reg <= 7'h00;
      wdata_reg <= 32'h0000_0000;
      pc_reg <= 32'h0000_0000;
    end else if (take) begin
      write_reg <= cp_write;
      major_reg <= cp_major;
      key_reg <= {cp_minor, cp_secondary};
      wdata_reg <= cp_wdata;
      pc_reg <= cp_pc;
    end
  end

  // A fault arriving with a register write to the same register wins.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_status_reg <= FAULT_STATUS_RESET;
      instr_status_reg <= FAULT_STATUS_RESET;
      fault_address_reg <= FAULT_ADDRESS_RESET;
    end else begin
      if (abort_now && abort_data) begin
        data_status_reg <= {data_status_reg[31:FSR_ZERO_BIT], fault_word[7:0]}; // [R2]
        fault_address_reg <= abort_addr; // [R6] [R7]
      end else begin
        if (wr_data_status) begin
          data_status_reg <= status_wdata; // [R1]
        end
        if (wr_fault_address) begin
          fault_address_reg <= wdata_reg; // [R8] [R24]
        end
      end
      if (abort_now && !abort_data) begin
        instr_status_reg <= {instr_status_reg[31:FSR_ZERO_BIT], fault_word[7:0]}; // [R7]
      end else if (wr_instr_status) begin
        instr_status_reg <= status_wdata; // [R1]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= RDATA_RESET;
      scan_ptr_reg <= '0;
      test_cnt_reg <= 16'h0000;
      wb_req_reg <= 1'b0;
      wb_addr_reg <= 32'h0000_0000;
      lf_req_reg <= 1'b0;
      lf_addr_reg <= 32'h0000_0000;
      wfi_link_reg <= 32'h0000_0000;
    end else begin
      if (finish && !write_reg) begin
        rdata_reg <= rdata_next; // [R24]
      end
      if (scan_adv) begin
        scan_ptr_reg <= scan_ptr_reg + 1'b1;
      end
      test_cnt_reg <= (state_reg == ST_TEST && !wb_start) ? test_cnt_reg + 16'h0001 : 16'h0000;
      if (wb_start) begin
        wb_addr_reg <= {dc_if.tag_out, dc_if.idx, 5'h00};
      end
      wb_req_reg <= wb_start || (wb_req_reg && !wb_ack);
      if (lf_start) begin
        lf_addr_reg <= {wdata_reg[ADDR_W-1:LINE_OFFSET_W], 5'h00};
      end
      lf_req_reg <= lf_start || (lf_req_reg && !lf_ack);
      if (finish && cmd == CMD_WFI) begin
        wfi_link_reg <= pc_reg + WFI_LINK_OFFSET; // [R19]
      end
    end
  end

  assign cp_busy = busy_reg;
  assign cp_done = done_reg;
  assign cp_rdata = rdata_reg;
  assign wb_req = wb_req_reg;
  assign wb_addr = wb_addr_reg;
  assign lf_req = lf_req_reg;
  assign lf_addr = lf_addr_reg;
  assign low_power = low_power_reg;
  assign wfi_link = wfi_link_reg;
endmodule

/* rtl/line_state_array.sv */
// Valid, dirty and tag state of one direct-mapped cache.
`timescale 1ns/1ps
module line_state_array
  import fault_cache_pkg::*;
#(
  parameter int IDX_W = 7
) (
  input wire logic clk,
  input wire logic rst_b,
  line_ops_if.store ops
);
  localparam int LINES = 1 << IDX_W;
  localparam int TAG_W = ADDR_W - LINE_OFFSET_W - IDX_W;

  logic [LINES-1:0] valid_reg;
  logic [LINES-1:0] dirty_reg;
  logic [TAG_W-1:0] tag_mem [LINES];

  wire logic tag_match = tag_mem[ops.idx] == ops.tag;
  wire logic line_hit = valid_reg[ops.idx] && tag_match;
  wire logic sel_ok = !ops.by_addr || line_hit;

  assign ops.valid = valid_reg[ops.idx];
  assign ops.dirty = dirty_reg[ops.idx];
  assign ops.hit = line_hit;
  assign ops.any_dirty = |dirty_reg;
  assign ops.tag_out = tag_mem[ops.idx];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      valid_reg <= '0;
      dirty_reg <= '0;
    end else begin
      unique case (ops.op)
        OP_INV_ALL: begin
          valid_reg <= '0;
          dirty_reg <= '0;
        end
        OP_INV_LINE: begin
          if (sel_ok) begin
            valid_reg[ops.idx] <= 1'b0;
            dirty_reg[ops.idx] <= 1'b0;
          end
        end
        OP_CLEAN: begin
          if (sel_ok) begin
            dirty_reg[ops.idx] <= 1'b0;
          end
        end
        OP_FILL: begin
          valid_reg[ops.idx] <= 1'b1;
          dirty_reg[ops.idx] <= 1'b0;
        end
        OP_DIRTY: begin
          if (line_hit) begin
            dirty_reg[ops.idx] <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (ops.op == OP_FILL) begin
      tag_mem[ops.idx] <= ops.tag;
    end
  end
endmodule

/* tb/fault_record_cache_maintenance_asserts.sv */
// Port checker for the fault record and cache maintenance block.
`timescale 1ns/1ps
module frcm_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cp_valid,
  input wire logic [3:0] cp_major,
  input wire logic cp_busy,
  input wire logic cp_done,
  input wire logic [31:0] cp_rdata,
  input wire logic wb_req,
  input wire logic wb_ack,
  input wire logic lf_req,
  input wire logic lf_ack,
  input wire logic wbuf_empty,
  input wire logic low_power
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_done_pulse: assert property (cp_done |=> !cp_done) else $error("done too wide");
  a_take_busy: assert property (cp_valid && !cp_busy |=> cp_busy) else $error("no busy");
  a_reg_latency: assert property (cp_valid && !cp_busy && cp_major inside {4'h5, 4'h6}
    |=> ##1 cp_done) else $error("register access late");
  a_busy_done: assert property ($fell(cp_busy) |-> cp_done) else $error("busy fell early");
  a_wb_hold: assert property (wb_req && !wb_ack |=> wb_req) else $error("wb dropped");
  a_wb_release: assert property (wb_req && wb_ack |=> !wb_req) else $error("wb stuck");
  a_lf_hold: assert property (lf_req && !lf_ack |=> lf_req) else $error("lf dropped");
  a_rdata_hold: assert property ($changed(cp_rdata) |-> cp_done) else $error("rdata moved");
  a_sleep_drained: assert property ($rose(low_power) |-> $past(wbuf_empty))
    else $error("slept before drain");
  a_wake_done: assert property ($fell(low_power) |-> cp_done) else $error("wake not done");
endmodule
bind fault_record_cache_maintenance frcm_asserts u_frcm_asserts (.clk, .rst_b, .cp_valid,
  .cp_major, .cp_busy, .cp_done, .cp_rdata, .wb_req, .wb_ack, .lf_req, .lf_ack, .wbuf_empty,
  .low_power);

/* tb/mem_responder.sv */
// Far side that finishes write-backs and linefills after a chosen delay.
`timescale 1ns/1ps
module mem_responder (
  input wire logic clk,
  input wire logic wb_req,
  input wire logic lf_req,
  input wire logic [3:0] delay,
  output logic wb_ack = 1'b0,
  output logic lf_ack = 1'b0
);
  logic [3:0] cnt_reg = 4'h0;
  always_ff @(posedge clk) begin
    wb_ack <= wb_req && !wb_ack && cnt_reg == delay;
    lf_ack <= lf_req && !lf_ack && !wb_req && cnt_reg == delay;
    cnt_reg <= (wb_req || lf_req) && cnt_reg != delay ? cnt_reg + 4'h1 : 4'h0;
  end
endmodule

/* tb/test_fault_record_cache_maintenance.sv */
// Self-checking bench for the fault record and cache maintenance block.
`timescale 1ns/1ps
module test_fault_record_cache_maintenance;
  import fault_cache_pkg::*;
  logic clk = 0, rst_b = 0, cp_valid = 0, cp_write = 0, abort_valid = 0, abort_data = 0;
  logic dc_fill_valid = 0, dc_store_valid = 0, wbuf_empty = 1, irq_pin = 0, rd = 0;
  logic [3:0] cp_major = 0, cp_minor = 0, abort_domain = 0, delay = 3;
  logic [2:0] cp_secondary = 0;
  logic [9:0] abort_kinds = 0;
  logic [31:0] cp_wdata = 0, cp_pc = 0, abort_addr = 0, dc_addr = 0, rv, wbs = 0, lfs = 0;
  logic cp_busy, cp_done, wb_req, wb_ack, lf_req, lf_ack, low_power;
  logic [31:0] cp_rdata, wfi_link, q[$];
  logic [6:0] keys [6] = '{KEY_INV_BOTH, KEY_INV_IC, KEY_INV_IC_ADDR, KEY_INV_IC_SETWAY,
    KEY_PREFETCH_IC, KEY_DRAIN};
  int n_fail = 0, compares = 0, seed = 32'hac62;
  fault_record_cache_maintenance u_fault_record_cache_maintenance (.clk, .rst_b, .cp_valid,
    .cp_write, .cp_major, .cp_minor, .cp_secondary, .cp_wdata, .cp_pc, .cp_busy, .cp_done,
    .cp_rdata, .abort_valid, .abort_data, .abort_kinds, .abort_domain, .abort_addr,
    .dc_fill_valid, .dc_fill_addr(dc_addr), .dc_store_valid, .dc_store_addr(dc_addr),
    .ic_fill_valid(1'b0), .ic_fill_addr(32'h0000_0000), .wb_req, .wb_addr(), .wb_ack, .lf_req,
    .lf_addr(), .lf_ack, .pf_cacheable(1'b1), .wbuf_empty, .irq_pin, .fiq_pin(1'b0),
    .dbg_req_pin(1'b0), .low_power, .wfi_link);
  mem_responder u_mem_responder (.clk, .wb_req, .lf_req, .delay, .wb_ack, .lf_ack);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    wbs <= wbs + 32'(wb_ack);
    lfs <= lfs + 32'(lf_ack);
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] mj, mn, input logic [2:0] sc,
    input logic [31:0] d);
    @(posedge clk);
    {cp_valid, cp_write, cp_major, cp_minor, cp_secondary, cp_wdata} <= {1'b1, w, mj, mn, sc, d};
    rd <= !w;
    @(posedge clk);
    cp_valid <= 1'b0;
    repeat (300) begin
      @(negedge clk);
      if (cp_done === 1'b1) break;
    end
    if (cp_done !== 1'b1) n_fail++;
  endtask
  task automatic rdchk(input logic [3:0] mj, mn, input logic [2:0] sc, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, mj, mn, sc, 32'h0000_0000);
  endtask
  task automatic fault(input logic dat, input logic [9:0] k, input logic [3:0] dom);
    @(posedge clk);
    {abort_valid, abort_data, abort_kinds, abort_domain, abort_addr} <=
      {1'b1, dat, k, dom, dat ? rv : ~rv};
    @(posedge clk);
    abort_valid <= 1'b0;
  endtask
  task automatic dirty_line();
    @(posedge clk);
    {dc_fill_valid, dc_addr} <= {1'b1, rv};
    @(posedge clk);
    {dc_fill_valid, dc_store_valid} <= 2'b01;
    @(posedge clk);
    dc_store_valid <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(negedge clk) if (cp_done === 1'b1 && rd) check("rdata", cp_rdata, q.pop_front());
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rv = $random(seed);
    xfer(1'b1, 4'h6, 4'h0, 3'h0, rv);
    rdchk(4'h6, 4'h0, 3'h0, rv);
    xfer(1'b1, 4'h5, 4'h0, 3'h0, 32'hffff_ffff);
    rdchk(4'h5, 4'h0, 3'h0, 32'hffff_feff);
    rv = $random(seed);
    fault(1'b1, 10'h201, 4'h3);
    rdchk(4'h5, 4'h0, 3'h0, 32'hffff_fe01);
    rdchk(4'h6, 4'h0, 3'h0, rv);
    fault(1'b1, 10'h204, 4'h9);
    rdchk(4'h5, 4'h0, 3'h0, 32'hffff_fe9e);
    fault(1'b1, 10'h008, 4'h5);
    rdchk(4'h5, 4'h0, 3'h0, 32'hffff_fe05);
    fault(1'b0, 10'h001, 4'h1);
    rdchk(4'h6, 4'h0, 3'h0, rv);
    $display("fault tests done");
    dirty_line();
    xfer(1'b1, 4'h7, 4'ha, 3'h1, rv);
    check("wbs", wbs, 32'h0000_0001);
    dirty_line();
    xfer(1'b1, 4'h7, 4'h6, 3'h0, 32'h0000_0000);
    rdchk(4'h7, 4'ha, 3'h3, 32'h4000_0000);
    check("wbs", wbs, 32'h0000_0001);
    rdchk(4'h7, 4'h7, 3'h5, 32'h0000_0000);
    foreach (keys[i]) xfer(1'b1, 4'h7, keys[i][6:3], keys[i][2:0], rv);
    check("lfs", lfs, 32'h0000_0001);
    $display("cache tests done");
    @(posedge clk) {wbuf_empty, cp_pc} <= {1'b0, rv};
    fork
      xfer(1'b1, 4'h7, 4'h0, 3'h4, 32'h0000_0000);
      begin
        repeat (10) @(posedge clk);
        wbuf_empty <= 1'b1;
        repeat (10) @(posedge clk);
        irq_pin <= 1'b1;
      end
    join
    @(posedge clk) irq_pin <= 1'b0;
    check("link", wfi_link, rv + 32'h0000_0008);
    $display("wait test done");
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule
